// file: hdl/fma_map.svh
// register map, field positions, codes and constants of the float accelerator
`ifndef FMA_MAP_SVH
`define FMA_MAP_SVH
// byte addresses
`define FMA_A_CTRL 5'h00
`define FMA_A_STAT 5'h04
`define FMA_A_RES 5'h08
`define FMA_A_OPA 5'h0C
`define FMA_A_OPB 5'h10
`define FMA_A_MASK 5'h14
// control fields
`define FMA_C_W 12
`define FMA_C_LAUNCH 0
`define FMA_C_OP 5:1
`define FMA_C_PASS 7:6
`define FMA_C_LEN 11:8
// status fields
`define FMA_S_W 12
`define FMA_S_DONE 0
`define FMA_S_BUSY 1
`define FMA_S_CMP 3:2
`define FMA_S_ZERO 4
`define FMA_S_INF 5
`define FMA_S_INV 6
`define FMA_S_TINY 7
`define FMA_S_HUGE 8
`define FMA_S_INX 9
`define FMA_S_IOVF 10
`define FMA_S_DZ 11
// mask fields
`define FMA_M_W 2
`define FMA_M_DONE 0
`define FMA_M_INV 1
// operation codes
`define FMA_OP_ATAN2 5'h03
`define FMA_OP_TRIG_LAST 5'h06
`define FMA_OP_SUM 5'h10
`define FMA_OP_SUM_OF_SQUARES 5'h11
`define FMA_OP_SUB 5'h12
`define FMA_OP_VECTOR_PRODUCT 5'h13
`define FMA_OP_DOT 5'h14
`define FMA_OP_MAC 5'h15
`define FMA_OP_DIV 5'h16
`define FMA_OP_INVRT 5'h17
`define FMA_OP_CMP 5'h18
`define FMA_OP_I2F 5'h19
`define FMA_OP_F2I 5'h1A
// compare outcomes
`define FMA_CMP_EQ 2'h0
`define FMA_CMP_LT 2'h1
`define FMA_CMP_GT 2'h2
`define FMA_CMP_UN 2'h3
// float constants and iteration counts
`define FMA_QNAN 32'h7FC00000
`define FMA_PINF 32'h7F800000
`define FMA_SIGN 32'h80000000
`define FMA_TWO 32'h40000000
`define FMA_HALF 32'h3F000000
`define FMA_THREEHALF 32'h3FC00000
`define FMA_RCP_SEED 32'h7EF311C7
`define FMA_RSQ_SEED 32'h5F3759DF
`define FMA_DIV_PASSES 3'h3
`define FMA_MAC_LIM 5'h03
`endif

// file: hdl/fma_pkg.sv
// types of the float accelerator
`include "fma_map.svh"
package fma_pkg;
  typedef enum logic [2:0] {S_IDLE = 3'h1, S_COLLECT = 3'h2, S_ITER = 3'h4} fma_state_type;
  typedef struct packed {
    fma_state_type st;
    logic [`FMA_C_W-1:0] ctl;
    logic [`FMA_S_W-1:0] stat;
    logic [`FMA_M_W-1:0] mask;
    logic [31:0] res;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [31:0] acc;
    logic [31:0] tmp;
    logic [31:0] hold;
    logic [31:0] xv;
    logic [4:0] cnt;
    logic [2:0] step;
    logic [2:0] pass;
    logic wrq;
    logic [31:0] rdata;
    logic irq;
  } fma_regs_type;
endpackage

// file: hdl/fma_top.sv
// memory-mapped single-precision float accelerator with avalon-mm slave
`timescale 1ns/1ns
`default_nettype none
`include "fma_map.svh"
// Behaviour
// - launch bit starts, self-clears, zero ignored
// - codes 0-6 trig, 7-15 reserved
// - codes 16-26 arithmetic, 27-31 reserved
// - refine passes set newton repetitions of the inverse root; division runs three passes except with zero, infinite or nan operands
// - bits 11:8 vector length, rest reserved
// - completion flag shows finished calculation
// - busy set at start, cleared at completion
// - compare outcome equal, less, greater, unordered
// - zero flag on zero result
// - infinity flag on infinite result
// - invalid flag on illegal input
// - tiny flag on underflowed nonzero result
// - huge flag on overflowed finite result
// - inexact flag when result was rounded
// - integer overflow flag on conversion overflow
// - divide by zero flag
// - mask bits gate completion and invalid
module fma_top
  import fma_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // interrupt request
  output logic irq
);
  fma_regs_type q;
  fma_regs_type n;
  logic [31:0] bm, rv, wv, fres;
  logic [35:0] r, r2;
  logic [4:0] opv, len, cnt1;
  logic [1:0] cmpv;
  logic req, stall, wr, wa, wb, launch, fin, fint, fkeep, took;

  function automatic logic isnan(input logic [31:0] a);
    return (&a[30:23]) && (|a[22:0]);
  endfunction
  function automatic logic isinf(input logic [31:0] a);
    return (&a[30:23]) && !(|a[22:0]);
  endfunction
  function automatic logic isz(input logic [31:0] a);
    return a[30:23] == 8'h00;
  endfunction

  // round to nearest even and pack; subnormals flush to zero
  function automatic logic [35:0] rnd(input logic s, input logic signed [9:0] e,
                                      input logic [26:0] m);
    logic [24:0] mm;
    logic signed [9:0] ee;
    mm = {1'b0, m[26:3]} + {24'h0, m[2] & (m[3] | (|m[1:0]))};
    ee = mm[24] ? e + 10'sd1 : e;
    if (mm[24]) mm = mm >> 1;
    if (ee >= 10'sd255) return {4'b0101, `FMA_PINF | {s, 31'h0}};
    if (ee <= 10'sd0) return {2'b00, |m, |m, s, 31'h0};
    return {3'b000, |m[2:0], s, ee[7:0], mm[22:0]};
  endfunction

  // result layout: invalid, huge, tiny, inexact, value
  function automatic logic [35:0] fmul(input logic [31:0] a, input logic [31:0] b);
    logic s;
    logic [47:0] p;
    logic signed [9:0] e;
    s = a[31] ^ b[31];
    if (isnan(a) | isnan(b) | (isinf(a) & isz(b)) | (isinf(b) & isz(a)))
      return {4'b1000, `FMA_QNAN};
    if (isinf(a) | isinf(b)) return {4'h0, `FMA_PINF | {s, 31'h0}};
    if (isz(a) | isz(b)) return {4'h0, s, 31'h0};
    p = {1'b1, a[22:0]} * {1'b1, b[22:0]};
    e = $signed({2'b00, a[30:23]}) + $signed({2'b00, b[30:23]}) - 10'sd127;
    if (p[47]) return rnd(s, e + 10'sd1, {p[47:22], |p[21:0]});
    return rnd(s, e, {p[46:21], |p[20:0]});
  endfunction

  function automatic logic [35:0] fadd(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] x, y;
    logic [7:0] d;
    logic [27:0] my, sm;
    logic signed [9:0] e;
    if (isnan(a) | isnan(b) | (isinf(a) & isinf(b) & (a[31] != b[31])))
      return {4'b1000, `FMA_QNAN};
    if (isinf(a) | isz(b)) return {4'h0, a};
    if (isinf(b) | isz(a)) return {4'h0, isz(b) ? {a[31] & b[31], 31'h0} : b};
    x = (a[30:0] < b[30:0]) ? b : a;
    y = (a[30:0] < b[30:0]) ? a : b;
    d = x[30:23] - y[30:23];
    my = {2'b01, y[22:0], 3'b000};
    if (d > 8'd26) my = 28'h1;
    else my = (my >> d) | {27'h0, |(my & ~({28{1'b1}} << d))};
    sm = (x[31] == y[31]) ? {2'b01, x[22:0], 3'b000} + my : {2'b01, x[22:0], 3'b000} - my;
    e = $signed({2'b00, x[30:23]});
    if (sm == 28'h0) return 36'h0;
    if (sm[27])
    begin
      sm = {1'b0, sm[27:2], sm[1] | sm[0]};
      e = e + 10'sd1;
    end
    for (int k = 0; k < 26; k++)
      if (!sm[26])
      begin
        sm = sm << 1;
        e = e - 10'sd1;
      end
    return rnd(x[31], e, sm[26:0]);
  endfunction

  function automatic logic [35:0] i2f(input logic [31:0] a);
    logic [31:0] u;
    logic signed [9:0] e;
    u = a[31] ? -a : a;
    e = 10'sd158;
    if (a == 32'h0) return 36'h0;
    for (int k = 0; k < 31; k++)
      if (!u[31])
      begin
        u = u << 1;
        e = e - 10'sd1;
      end
    return rnd(a[31], e, {u[31:6], |u[5:0]});
  endfunction

  // layout: invalid, integer overflow, unused, inexact, value
  function automatic logic [35:0] f2i(input logic [31:0] a);
    logic [55:0] w;
    logic [31:0] i;
    logic inx;
    if (isnan(a)) return {4'b1100, 32'h7FFFFFFF};
    if (a[30:23] < 8'd126) return {3'b000, |a[30:0], 32'h0};
    if (a[30:23] > 8'd157)
      return (a == 32'hCF000000) ? {4'h0, `FMA_SIGN} :
             {4'b0100, a[31] ? `FMA_SIGN : 32'h7FFFFFFF};
    if (a[30:23] >= 8'd150)
    begin
      i = {8'h0, 1'b1, a[22:0]} << (a[30:23] - 8'd150);
      inx = 1'b0;
    end
    else
    begin
      w = {8'h0, 1'b1, a[22:0], 24'h0} >> (8'd150 - a[30:23]);
      i = w[55:24] + {31'h0, w[23] & (w[24] | (|w[22:0]))};
      inx = |w[23:0];
    end
    return {1'b0, ~a[31] & i[31], 1'b0, inx, a[31] ? -i : i};
  endfunction

  function automatic logic [1:0] fcmp(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] ka, kb;
    ka = a[31] ? ~a : {1'b1, a[30:0]};
    kb = b[31] ? ~b : {1'b1, b[30:0]};
    if (isnan(a) | isnan(b)) return `FMA_CMP_UN;
    if ((a[30:0] == 31'h0 && b[30:0] == 31'h0) || ka == kb) return `FMA_CMP_EQ;
    return (ka < kb) ? `FMA_CMP_LT : `FMA_CMP_GT;
  endfunction

  // or one step's exception bits into the status
  function automatic logic [`FMA_S_W-1:0] fl(input logic [`FMA_S_W-1:0] st, input logic [35:0] x);
    st[`FMA_S_INV] = st[`FMA_S_INV] | x[35];
    st[`FMA_S_HUGE] = st[`FMA_S_HUGE] | x[34];
    st[`FMA_S_TINY] = st[`FMA_S_TINY] | x[33];
    st[`FMA_S_INX] = st[`FMA_S_INX] | x[32];
    return st;
  endfunction

  // byte-enable mask for writes
  assign bm = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
               {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign cmpv = fcmp(q.hold, wv);

  // read mux, also the base for byte-masked writes; unmapped reads give zero
  always_comb
  begin
    case (avs_address)
      `FMA_A_CTRL: rv = {20'h0, q.ctl};
      `FMA_A_STAT: rv = {20'h0, q.stat};
      `FMA_A_RES: rv = q.res;
      `FMA_A_OPA: rv = q.opa;
      `FMA_A_OPB: rv = q.opb;
      `FMA_A_MASK: rv = {30'h0, q.mask};
      default: rv = 32'h0;
    endcase
    wv = (rv & ~bm) | (avs_writedata & bm);
  end

  // whole next-state computation
  always_comb
  begin
    n = q;
    r = 36'h0;
    r2 = 36'h0;
    fin = 1'b0;
    fint = 1'b0;
    fkeep = 1'b0;
    took = 1'b0;
    fres = q.res;
    opv = q.ctl[`FMA_C_OP];
    len = (q.ctl[`FMA_C_LEN] == 4'h0) ? 5'h01 : {1'b0, q.ctl[`FMA_C_LEN]};
    cnt1 = q.cnt + 5'h01;
    req = avs_read | avs_write;
    // operand writes wait while the newton loop owns the datapath
    stall = (q.st == S_ITER) && (avs_address == `FMA_A_OPA || avs_address == `FMA_A_OPB);
    wr = avs_write && !q.wrq;
    wa = wr && avs_address == `FMA_A_OPA;
    wb = wr && avs_address == `FMA_A_OPB;
    launch = wr && avs_address == `FMA_A_CTRL && wv[`FMA_C_LAUNCH];
    // answer one cycle after the request, then accept on the low-wait edge
    n.wrq = 1'b1;
    if (req && q.wrq && !stall)
    begin
      n.wrq = 1'b0;
      n.rdata = rv;
    end
    // software writes come first so hardware updates below win
    if (wr)
      case (avs_address)
        `FMA_A_CTRL: n.ctl = {wv[`FMA_C_W-1:1], 1'b0};
        `FMA_A_STAT: n.stat = wv[`FMA_S_W-1:0];
        `FMA_A_OPA: n.opa = wv;
        `FMA_A_OPB: n.opb = wv;
        `FMA_A_MASK: n.mask = wv[`FMA_M_W-1:0];
        default: n.rdata = n.rdata;
      endcase
    if (launch)
    begin
      n.stat = '0;
      n.stat[`FMA_S_BUSY] = 1'b1;
      n.st = S_COLLECT;
      n.cnt = 5'h00;
      if ((wv[`FMA_C_OP] > `FMA_OP_TRIG_LAST && wv[`FMA_C_OP] < `FMA_OP_SUM) ||
          wv[`FMA_C_OP] > `FMA_OP_F2I)
      begin
        n.stat[`FMA_S_INV] = 1'b1;
        fres = `FMA_QNAN;
        fin = 1'b1;
      end
    end
    else if (q.st == S_COLLECT && (wa || wb))
    begin
      case (opv)
        `FMA_OP_SUM, `FMA_OP_SUM_OF_SQUARES, `FMA_OP_SUB, `FMA_OP_VECTOR_PRODUCT:
        begin
          r2 = fmul(wv, wv);
          if (wa && q.cnt == 5'h00)
          begin
            r = (opv == `FMA_OP_SUM_OF_SQUARES) ? r2 : {4'h0, wv};
            took = 1'b1;
          end
          else if (wb && q.cnt != 5'h00)
          begin
            took = 1'b1;
            case (opv)
              `FMA_OP_SUM: r = fadd(q.acc, wv);
              `FMA_OP_SUB: r = fadd(q.acc, wv ^ `FMA_SIGN);
              `FMA_OP_VECTOR_PRODUCT: r = fmul(q.acc, wv);
              default: r = fadd(q.acc, r2[31:0]) | {r2[35:32], 32'h0};
            endcase
          end
        end
        `FMA_OP_DOT:
          if (wa) n.hold = wv;
          else
          begin
            r2 = fmul(q.hold, wv);
            r = (q.cnt == 5'h00) ? r2 : (fadd(q.acc, r2[31:0]) | {r2[35:32], 32'h0});
            took = 1'b1;
          end
        `FMA_OP_MAC:
          if (wa && q.cnt == 5'h00)
          begin
            n.hold = wv;
            n.cnt = 5'h01;
          end
          else if (wb && q.cnt != 5'h00)
          begin
            r = (q.cnt == 5'h01) ? fmul(q.hold, wv) : fadd(q.acc, wv);
            took = 1'b1;
          end
        `FMA_OP_CMP, `FMA_OP_ATAN2:
          if (wa)
          begin
            n.hold = wv;
            n.cnt = 5'h01;
          end
          else if (q.cnt == 5'h01)
          begin
            fin = 1'b1;
            fkeep = (opv == `FMA_OP_CMP);
            fres = `FMA_QNAN;
            if (opv == `FMA_OP_CMP) n.stat[`FMA_S_CMP] = cmpv;
            else n.stat[`FMA_S_INV] = 1'b1;
          end
        `FMA_OP_DIV:
          if (wa && q.cnt == 5'h00)
          begin
            n.hold = wv;
            n.cnt = 5'h01;
          end
          else if (wa)
          begin
            fin = 1'b1;
            fres = {q.hold[31] ^ wv[31], 31'h0};
            if (isnan(q.hold) | isnan(wv) | (isz(q.hold) & isz(wv)) |
                (isinf(q.hold) & isinf(wv)))
            begin
              fres = `FMA_QNAN;
              n.stat[`FMA_S_INV] = 1'b1;
            end
            else if (isz(wv))
            begin
              fres = fres | `FMA_PINF;
              n.stat[`FMA_S_DZ] = 1'b1;
            end
            else if (isinf(q.hold)) fres = fres | `FMA_PINF;
            else if (!isinf(wv) && !isz(q.hold))
            begin
              fin = 1'b0;
              n.xv = wv;
              n.acc = `FMA_RCP_SEED - {1'b0, wv[30:0]};
              n.st = S_ITER;
              n.step = 3'h0;
              n.pass = 3'h0;
            end
          end
        `FMA_OP_INVRT:
          if (wa)
          begin
            fin = 1'b1;
            fres = 32'h0;
            if (isnan(wv) | (wv[31] & !isz(wv)))
            begin
              fres = `FMA_QNAN;
              n.stat[`FMA_S_INV] = 1'b1;
            end
            else if (isz(wv))
            begin
              fres = {wv[31], 31'h0} | `FMA_PINF;
              n.stat[`FMA_S_DZ] = 1'b1;
            end
            else if (!isinf(wv))
            begin
              fin = 1'b0;
              n.xv = wv;
              n.acc = `FMA_RSQ_SEED - {1'b0, wv[31:1]};
              n.st = S_ITER;
              n.step = 3'h0;
              n.pass = 3'h0;
            end
          end
        `FMA_OP_I2F:
          if (wa)
          begin
            r = i2f(wv);
            n.stat = fl(n.stat, r);
            fres = r[31:0];
            fin = 1'b1;
          end
        `FMA_OP_F2I:
          if (wa)
          begin
            r = f2i(wv);
            n.stat[`FMA_S_INV] = r[35];
            n.stat[`FMA_S_IOVF] = r[34];
            n.stat[`FMA_S_INX] = r[32];
            fres = r[31:0];
            fint = 1'b1;
            fin = 1'b1;
          end
        default:
          if (wa)
          begin
            // transcendental modes have no datapath and return invalid
            n.stat[`FMA_S_INV] = 1'b1;
            fres = `FMA_QNAN;
            fin = 1'b1;
          end
      endcase
      if (took)
      begin
        n.acc = r[31:0];
        n.stat = fl(n.stat, r);
        n.cnt = cnt1;
        fres = r[31:0];
        fin = cnt1 >= ((opv == `FMA_OP_MAC) ? `FMA_MAC_LIM : len);
      end
    end
    else if (q.st == S_ITER)
    begin
      // newton steps share one multiplier and one adder per cycle
      n.step = q.step + 3'h1;
      if (opv == `FMA_OP_DIV)
        case (q.step)
          3'h0: r2 = fmul({1'b0, q.xv[30:0]}, q.acc);
          3'h1: r2 = fadd(`FMA_TWO, q.tmp ^ `FMA_SIGN);
          3'h2:
          begin
            r2 = fmul(q.acc, q.tmp);
            n.acc = r2[31:0];
            n.pass = q.pass + 3'h1;
            n.step = (q.pass + 3'h1 == `FMA_DIV_PASSES) ? 3'h3 : 3'h0;
          end
          default:
          begin
            r = fmul(q.hold, {q.xv[31], q.acc[30:0]});
            fin = 1'b1;
          end
        endcase
      else
        case (q.step)
          3'h0: r2 = fmul(q.acc, q.acc);
          3'h1: r2 = fmul(q.xv, q.tmp);
          3'h2: r2 = fmul(`FMA_HALF, q.tmp);
          3'h3: r2 = fadd(`FMA_THREEHALF, q.tmp ^ `FMA_SIGN);
          default:
          begin
            r = fmul(q.acc, q.tmp);
            n.acc = r[31:0];
            n.pass = q.pass + 3'h1;
            n.step = 3'h0;
            fin = (q.pass == {1'b0, q.ctl[`FMA_C_PASS]});
          end
        endcase
      // inner step flags are dropped; only the value carries on
      n.tmp = r2[31:0];
      if (fin)
      begin
        n.stat = fl(n.stat, r);
        n.stat[`FMA_S_INX] = 1'b1;
        fres = r[31:0];
      end
    end
    if (fin)
    begin
      n.st = S_IDLE;
      n.stat[`FMA_S_BUSY] = 1'b0;
      n.stat[`FMA_S_DONE] = 1'b1;
      if (!fkeep)
      begin
        n.res = fres;
        n.stat[`FMA_S_ZERO] = fint ? (fres == 32'h0) : (fres[30:0] == 31'h0);
        n.stat[`FMA_S_INF] = !fint && (fres[30:0] == `FMA_PINF);
      end
    end
    n.irq = (n.stat[`FMA_S_DONE] & ~n.mask[`FMA_M_DONE]) |
            (n.stat[`FMA_S_INV] & ~n.mask[`FMA_M_INV]);
  end

  // single state register
  always_ff @(posedge clk)
  begin
    if (!nrst) q <= '{st: S_IDLE, wrq: 1'b1, default: '0};
    else q <= n;
  end

  assign avs_readdata = q.rdata;
  assign avs_waitrequest = q.wrq;
  assign irq = q.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_launch_busy;
    launch && wv[`FMA_C_OP] == `FMA_OP_SUM |=> q.stat[`FMA_S_BUSY] && !q.stat[`FMA_S_DONE]
      && q.ctl[`FMA_C_LAUNCH] == 1'b0;
  endproperty
  a_launch_busy: assert property (p_launch_busy) else $error("launch did not set busy");
  property p_launch_clear;
    launch |=> q.stat[`FMA_S_W-1:`FMA_S_ZERO] == '0 || q.stat[`FMA_S_INV];
  endproperty
  a_launch_clear: assert property (p_launch_clear) else $error("flags kept over launch");
  property p_done_idle;
    $rose(q.stat[`FMA_S_DONE]) && !($past(wr) && $past(avs_address) == `FMA_A_STAT) |->
      !q.stat[`FMA_S_BUSY] && q.st == S_IDLE;
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("done while still busy");
  property p_irq;
    irq == ((q.stat[`FMA_S_DONE] && !q.mask[`FMA_M_DONE]) ||
            (q.stat[`FMA_S_INV] && !q.mask[`FMA_M_INV]));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt disagrees with flags");
  property p_ctrl_read;
    avs_read && !q.wrq && avs_address == `FMA_A_CTRL |->
      avs_readdata[`FMA_C_LAUNCH] == 1'b0 && avs_readdata[31:`FMA_C_W] == '0;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");
  property p_cmp;
    wb && !launch && q.st == S_COLLECT && opv == `FMA_OP_CMP && q.cnt == 5'h01 |=>
      q.stat[`FMA_S_CMP] == $past(cmpv) && q.stat[`FMA_S_DONE];
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare outcome wrong");
  property p_dz;
    wa && q.st == S_COLLECT && opv == `FMA_OP_DIV && q.cnt == 5'h01 && isz(wv) &&
      !isz(q.hold) && !isnan(q.hold) |=> q.stat[`FMA_S_DZ] && q.stat[`FMA_S_INF];
  endproperty
  a_dz: assert property (p_dz) else $error("division by zero not flagged");
  property p_iter_end;
    $rose(q.st == S_ITER) |-> ##[1:24] q.stat[`FMA_S_DONE];
  endproperty
  a_iter_end: assert property (p_iter_end) else $error("newton loop did not finish");
endmodule
`default_nettype wire

// file: verification/fma_top_tb.sv
// self-checking bench of the float accelerator through its avalon register port
`timescale 1ns/1ns
`default_nettype none
`include "fma_map.svh"
module fma_top_tb;
  import fma_pkg::*;
  // bus side of the bench
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  int failures = 0;
  int samples_checked = 0;
  logic [31:0] st;
  logic [31:0] rs;
  // 10 mhz clock
  always #50 clk = ~clk;
  fma_top u_fma_top (.clk(clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hF),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));
  task automatic conclude;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chb(input logic b);
    chk({31'h0, b}, 32'h1);
  endtask
  // one access; request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    // no cycle count assumed; a hang is left to the watchdog
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h00000000, q);
  endtask
  // poll completion, bounded, then fetch the result
  task automatic fin;
    int n;
    n = 0;
    do
    begin
      rd(`FMA_A_STAT, st);
      n++;
    end
    while (st[0] !== 1'b1 && n < 100);
    chk({30'h0, st[1:0]}, 32'h1);
    rd(`FMA_A_RES, rs);
  endtask
  task automatic t_reset;
    rd(`FMA_A_RES, rs);
    chk(rs, 32'h00000000);
    rd(`FMA_A_OPA, rs);
    chk(rs, 32'h00000000);
    wr(`FMA_A_RES, 32'h12345678);
    rd(`FMA_A_RES, rs);
    chk(rs, 32'h00000000);
    rd(5'h18, rs);
    chk(rs, 32'h00000000);
  endtask
  task automatic t_sum;
    wr(`FMA_A_MASK, 32'h00000000);
    wr(`FMA_A_CTRL, 32'h00000221);
    rd(`FMA_A_CTRL, rs);
    chk(rs, 32'h00000220);
    rd(`FMA_A_STAT, st);
    chk({30'h0, st[1:0]}, 32'h2);
    wr(`FMA_A_OPA, 32'h3F800000);
    wr(`FMA_A_OPB, 32'h40000000);
    fin;
    chk(rs, 32'h40400000);
    chb(irq);
    wr(`FMA_A_MASK, 32'h00000001);
    repeat (2) @(posedge clk);
    chb(!irq);
  endtask
  task automatic t_dot;
    wr(`FMA_A_CTRL, 32'h00000229);
    wr(`FMA_A_OPA, 32'h3F800000);
    wr(`FMA_A_OPB, 32'h40000000);
    wr(`FMA_A_OPA, 32'h40400000);
    wr(`FMA_A_OPB, 32'h40800000);
    fin;
    chk(rs, 32'h41600000);
  endtask
  // zero, overflow, tiny and divide by zero outcomes
  task automatic t_range;
    wr(`FMA_A_CTRL, 32'h00000225);
    wr(`FMA_A_OPA, 32'h3F800000);
    wr(`FMA_A_OPB, 32'h3F800000);
    fin;
    chb(st[`FMA_S_ZERO]);
    wr(`FMA_A_CTRL, 32'h00000227);
    wr(`FMA_A_OPA, 32'h7F000000);
    wr(`FMA_A_OPB, 32'h7F000000);
    fin;
    chk(rs, 32'h7F800000);
    chb(st[`FMA_S_INF] & st[`FMA_S_HUGE]);
    wr(`FMA_A_CTRL, 32'h00000227);
    wr(`FMA_A_OPA, 32'h00800000);
    wr(`FMA_A_OPB, 32'h3F000000);
    fin;
    chb(st[`FMA_S_TINY]);
    wr(`FMA_A_CTRL, 32'h0000002D);
    wr(`FMA_A_OPA, 32'h3F800000);
    wr(`FMA_A_OPA, 32'h00000000);
    fin;
    chb(st[`FMA_S_DZ]);
  endtask
  task automatic t_cmp;
    logic [31:0] p[4] = '{32'h3F800000, 32'h40000000, 32'h3F800000, 32'h7FC00000};
    logic [31:0] q[4] = '{32'h40000000, 32'h3F800000, 32'h3F800000, 32'h3F800000};
    logic [1:0] e[4] = '{2'h1, 2'h2, 2'h0, 2'h3};
    for (int i = 0; i < 4; i++)
    begin
      wr(`FMA_A_CTRL, 32'h00000031);
      wr(`FMA_A_OPA, p[i]);
      wr(`FMA_A_OPB, q[i]);
      fin;
      chk({30'h0, st[3:2]}, {30'h0, e[i]});
    end
  endtask
  // reserved codes end at once as invalid; a new launch clears flags
  task automatic t_reserved;
    logic [31:0] c[2] = '{32'h0000000F, 32'h00000037};
    for (int i = 0; i < 2; i++)
    begin
      wr(`FMA_A_CTRL, c[i]);
      fin;
      chk(rs, 32'h7FC00000);
      chb(st[`FMA_S_INV]);
    end
    wr(`FMA_A_CTRL, 32'h00000221);
    rd(`FMA_A_STAT, st);
    chk({20'h0, st[11:0]} & 32'h00000FF1, 32'h00000000);
  endtask
  task automatic t_conv;
    wr(`FMA_A_CTRL, 32'h00000033);
    wr(`FMA_A_OPA, 32'h00000005);
    fin;
    chk(rs, 32'h40A00000);
    wr(`FMA_A_CTRL, 32'h00000035);
    wr(`FMA_A_OPA, 32'h7FC00000);
    fin;
    chb(st[`FMA_S_IOVF] & st[`FMA_S_INV]);
    chb(irq);
    wr(`FMA_A_MASK, 32'h00000003);
    repeat (2) @(posedge clk);
    chb(!irq);
    wr(`FMA_A_CTRL, 32'h000000EF);
    wr(`FMA_A_OPA, 32'h40800000);
    fin;
    chb(rs > 32'h3EFFFF00 && rs < 32'h3F000100);
    chb(st[`FMA_S_INX]);
  endtask
  // sum of squares, multiply-add, a full newton division and a trig code
  task automatic t_more;
    wr(`FMA_A_CTRL, 32'h00000223);
    wr(`FMA_A_OPA, 32'h40000000);
    wr(`FMA_A_OPB, 32'h40400000);
    fin;
    chk(rs, 32'h41500000);
    wr(`FMA_A_CTRL, 32'h0000002B);
    wr(`FMA_A_OPA, 32'h40000000);
    wr(`FMA_A_OPB, 32'h40400000);
    wr(`FMA_A_OPB, 32'h3F800000);
    fin;
    chk(rs, 32'h40E00000);
    wr(`FMA_A_CTRL, 32'h0000002D);
    wr(`FMA_A_OPA, 32'h40C00000);
    wr(`FMA_A_OPA, 32'h40000000);
    fin;
    chb(rs > 32'h403FFF00 && rs < 32'h40400100);
    chb(st[`FMA_S_INX] & !st[`FMA_S_DZ]);
    wr(`FMA_A_CTRL, 32'h00000007);
    wr(`FMA_A_OPA, 32'h3F800000);
    wr(`FMA_A_OPB, 32'h3F800000);
    fin;
    chk(rs, 32'h7FC00000);
    chb(st[`FMA_S_INV]);
  endtask
  // main sequence; reset held sixteen cycles
  initial
  begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_sum;
    t_dot;
    t_range;
    t_cmp;
    t_reserved;
    t_conv;
    t_more;
    conclude;
  end
  // watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    conclude;
  end
endmodule
`default_nettype wire
